//--- rcd_ctrl.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - four-bit rate code picks periodic period; code 0 never fires
// - update-inhibit bit stops once-per-second updates while set
// - config bits 6..4 gate periodic, alarm, update-ended interrupts
// - config bit 2 picks binary (1) or BCD (0) at the interface
// - config bit 1 picks 24-hour (1) or 12-hour with meridian (0)
// - config bit 0 enables automatic season hour shifts
// - format bits only convert on access; stored values unchanged
// - flag bit 7 is the OR of enabled flags 6..4
// - flags 6..4 latch their events regardless of config bits 6..4
// - reading the flag register clears every flag not set again in that cycle
// - update-ended flag after an update; time then stable a second
// - nonzero date qualifier must match the month or alarm blocked
// - control bit 3 enables the alarm features
// - control bit 2 routes the alarm to the wake circuitry
// - control bit 1 soft-resets all but control; clears itself
// - nothing runs until control bit 0 is one
// - weekday qualifier 1..7 must match; 11xxxxxx reads back FFh
// - spring schedule match adds one extra hour
// - week of month kept internally; code 5 is the last week
// - fall match holds the hour once, then rearms after repeat
// - schedules are byte-writable; software disables before bytes
// - schedule hour and month converted with modes at write time
// - skipped hour alarms never fire, repeated hour alarms twice
// - alarm time byte 11xxxxxx always matches
// - update-in-progress raised 16 slow ticks before update
module rcd_ctrl #(
  parameter int DIV_BITS = rcd_pkg::DIV_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clk_32k,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic [3:0] i_reg_be,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic [5:0] i_sec,
  input wire logic [5:0] i_min,
  input wire logic [4:0] i_hour,
  input wire logic [2:0] i_wday,
  input wire logic [4:0] i_mday,
  input wire logic [4:0] i_mon_days,
  input wire logic [3:0] i_mon,
  input wire logic i_update_done,
  output logic o_update_go,
  output logic o_hour_extra,
  output logic o_hour_hold,
  output logic o_bin_mode,
  output logic o_h24_mode,
  output logic o_uip,
  output logic o_running,
  output logic o_irq,
  output logic o_wake_alarm
);
  import rcd_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic [31:0] rd_q;
    logic [7:0] cfg;
    logic [3:0] rate;
    logic [2:0] divsel;
    logic [2:0] flags;
    logic [5:0] dq;
    logic [3:0] ctl;
    logic [7:0] wq;
    logic [7:0] a_sec;
    logic [7:0] a_min;
    logic [7:0] a_hr;
    rcd_sched_t spring;
    rcd_sched_t fall;
    logic fall_armed;
    logic upd_go;
    logic extra;
    logic hold;
    logic wake;
  } rcd_st_t;

  localparam rcd_st_t ST_RST = '{wq: DONT_CARE, fall_armed: 1'b1,
      default: '0};

  rcd_st_t st_q;
  rcd_st_t st_d;
  logic bin;
  logic h24;
  logic run;
  logic roll;
  logic sp_hit;
  logic fa_hit;
  logic alm_hit;
  logic irqf;
  logic [4:0] nxt_hr;
  logic [2:0] flag_set;
  logic [31:0] rd_val;

  rcd_tb_if tb();

  rcd_timebase #(.DIV_BITS(DIV_BITS)) u_timebase (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .tb(tb.div)
  );

  assign bin = st_q.cfg[CFG_BIN];
  assign h24 = st_q.cfg[CFG_H24];
  // halted divider select stops counting as well as the enable
  assign run = st_q.ctl[CTL_EN] && st_q.divsel[2:1] != DIV_HALT;
  assign tb.run = run;
  assign tb.tick = st_q.lvl == 1'b0 && st_q.sync[2:1] == 2'b11;
  assign tb.clr = st_q.ctl[CTL_SOFT];
  assign tb.rate = st_q.rate;

  // last second of the hour: the coming update crosses into nxt_hr
  assign roll = tb.sec_evt && i_min == LAST_MIN_SEC
      && i_sec == LAST_MIN_SEC;
  assign nxt_hr = (i_hour == LAST_HOUR) ? 5'h00 : i_hour + 5'h01;
  assign sp_hit = st_q.cfg[CFG_DST] && roll
      && sched_hit(st_q.spring, nxt_hr, i_wday, i_mday, i_mon_days,
      i_mon);
  assign fa_hit = st_q.cfg[CFG_DST] && roll && st_q.fall_armed
      && sched_hit(st_q.fall, nxt_hr, i_wday, i_mday, i_mon_days,
      i_mon);

  // judged on the freshly updated time, so a skipped hour never matches
  // and a repeated hour matches again
  assign alm_hit = i_update_done && run && st_q.ctl[CTL_ALM]
      && (st_q.a_sec == DONT_CARE || st_q.a_sec == {2'h0, i_sec})
      && (st_q.a_min == DONT_CARE || st_q.a_min == {2'h0, i_min})
      && (st_q.a_hr == DONT_CARE || st_q.a_hr == {3'h0, i_hour})
      && (st_q.dq == 6'h00 || st_q.dq == {2'h0, i_mon})
      && (st_q.wq == DONT_CARE || st_q.wq == {5'h00, i_wday});

  assign flag_set = {tb.per_evt, alm_hit, i_update_done && run};
  assign irqf = |(st_q.flags & st_q.cfg[CFG_PIE:CFG_UIE]);

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (i_reg_addr)
      OFS_ALM_SEC: rd_val[7:0] = alm_out(st_q.a_sec, bin, h24, 1'b0);
      OFS_ALM_MIN: rd_val[7:0] = alm_out(st_q.a_min, bin, h24, 1'b0);
      OFS_ALM_HR: rd_val[7:0] = alm_out(st_q.a_hr, bin, h24, 1'b1);
      OFS_RATE: rd_val[7:0] = {tb.uip, st_q.divsel, st_q.rate};
      OFS_CFG: rd_val[7:0] = st_q.cfg;
      OFS_FLAGS: rd_val[7:0] = {irqf, st_q.flags, 4'h0};
      OFS_DATE_Q: rd_val[7:0] = {2'h0, 6'(enc({2'h0, st_q.dq}, bin))};
      OFS_CTL: rd_val[7:0] = {4'h0, st_q.ctl};
      OFS_WDAY_Q: rd_val[7:0] = st_q.wq;
      OFS_SPRING: rd_val = sched_rd(st_q.spring, bin, h24);
      OFS_FALL: rd_val = sched_rd(st_q.fall, bin, h24);
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    if (st_q.ctl[CTL_SOFT]) begin
      // one-cycle soft reset spares the control register
      st_d = ST_RST;
      st_d.ctl = st_q.ctl & ~CTL_SOFT_MASK;
    end
    st_d.sync = {st_q.sync[1:0], i_clk_32k};
    st_d.lvl = st_q.lvl;
    if (st_q.sync[2] == st_q.sync[1]) begin
      st_d.lvl = st_q.sync[2];
    end
    st_d.rd_q = 32'h0000_0000;
    // one update per divider wrap keeps the time still for a second
    st_d.upd_go = tb.sec_evt && !st_q.cfg[CFG_INHIBIT];
    st_d.extra = st_d.upd_go && sp_hit && !fa_hit;
    st_d.hold = st_d.upd_go && fa_hit;
    st_d.wake = alm_hit && st_q.ctl[CTL_WAKE];
    if (st_d.upd_go && roll) begin
      // a hit disarms; the next unheld roll rearms
      st_d.fall_armed = !fa_hit;
    end
    st_d.flags = st_d.flags | flag_set;
    if (i_reg_rd) begin
      st_d.rd_q = rd_val;
      if (i_reg_addr == OFS_FLAGS) begin
        // a new event in the same cycle survives the clear
        st_d.flags = flag_set;
      end
    end
    if (i_reg_wr) begin
      if (i_reg_be[0]) begin
        unique case (i_reg_addr)
          OFS_ALM_SEC: st_d.a_sec = alm_in(i_reg_wdata[7:0], bin, h24,
              1'b0);
          OFS_ALM_MIN: st_d.a_min = alm_in(i_reg_wdata[7:0], bin, h24,
              1'b0);
          OFS_ALM_HR: st_d.a_hr = alm_in(i_reg_wdata[7:0], bin, h24,
              1'b1);
          OFS_RATE: begin
            st_d.rate = i_reg_wdata[3:0];
            st_d.divsel = i_reg_wdata[6:4];
          end
          OFS_CFG: st_d.cfg = i_reg_wdata[7:0] & CFG_WMASK;
          OFS_DATE_Q: st_d.dq = 6'(dec({2'h0, i_reg_wdata[5:0]}, bin));
          OFS_CTL: st_d.ctl = i_reg_wdata[3:0];
          OFS_WDAY_Q: st_d.wq = (i_reg_wdata[7:6] == DC_TOP) ? DONT_CARE
              : i_reg_wdata[7:0];
          default: st_d.rd_q = st_d.rd_q;
        endcase
      end
      if (i_reg_addr == OFS_SPRING) begin
        st_d.spring = sched_wr(st_q.spring, i_reg_wdata, i_reg_be, bin,
            h24);
      end
      if (i_reg_addr == OFS_FALL) begin
        st_d.fall = sched_wr(st_q.fall, i_reg_wdata, i_reg_be, bin,
            h24);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reg_rdata = st_q.rd_q;
  assign o_update_go = st_q.upd_go;
  assign o_hour_extra = st_q.extra;
  assign o_hour_hold = st_q.hold;
  assign o_bin_mode = bin;
  assign o_h24_mode = h24;
  assign o_uip = tb.uip;
  assign o_running = run;
  assign o_irq = irqf;
  assign o_wake_alarm = st_q.wake;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_wq_dc_wr;
    i_reg_wr && i_reg_be[0] && i_reg_addr == OFS_WDAY_Q
        && i_reg_wdata[7:6] == DC_TOP;
  endsequence
  sequence s_wq_rd;
    i_reg_rd && i_reg_addr == OFS_WDAY_Q;
  endsequence
  sequence s_soft_wr;
    i_reg_wr && i_reg_be[0] && i_reg_addr == OFS_CTL
        && i_reg_wdata[CTL_SOFT];
  endsequence

  property p_wq_dc;
    s_wq_dc_wr ##1 !i_reg_wr ##1 s_wq_rd |=> o_reg_rdata[7:0] == DONT_CARE;
  endproperty
  a_wq_dc: assert property (p_wq_dc)
    else $error("weekday qualifier did not read back FFh");

  property p_rd_clr;
    i_reg_rd && i_reg_addr == OFS_FLAGS && flag_set == 3'h0
        |=> st_q.flags == 3'h0;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("flag read did not clear flags");

  property p_irqf;
    i_reg_rd && i_reg_addr == OFS_FLAGS |=> o_reg_rdata[7] == $past(irqf);
  endproperty
  a_irqf: assert property (p_irqf)
    else $error("request bit disagrees with enabled flags");

  property p_inhibit;
    o_update_go |-> !$past(st_q.cfg[CFG_INHIBIT]);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("update issued while inhibited");

  property p_uf;
    i_update_done && run |=> st_q.flags[0];
  endproperty
  a_uf: assert property (p_uf)
    else $error("update-ended flag not latched");

  property p_off;
    !st_q.ctl[CTL_EN] [*3] |-> !o_update_go;
  endproperty
  a_off: assert property (p_off)
    else $error("update while block disabled");

  property p_wake;
    o_wake_alarm |-> $past(st_q.ctl[CTL_WAKE]) && $past(alm_hit);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse without routed alarm");

  property p_alm_en;
    $rose(st_q.flags[1]) |-> $past(st_q.ctl[CTL_ALM] && run);
  endproperty
  a_alm_en: assert property (p_alm_en)
    else $error("alarm flag set while alarms disabled");

  property p_soft;
    s_soft_wr ##1 !i_reg_wr |-> st_q.ctl[CTL_SOFT]
        ##1 (!st_q.ctl[CTL_SOFT] && st_q.cfg == CFG_RST);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset did not pulse and clear");

  property p_fall;
    o_hour_hold |-> !st_q.fall_armed && !o_hour_extra;
  endproperty
  a_fall: assert property (p_fall)
    else $error("fall match left armed");

  property p_per_flag;
    tb.per_evt |=> st_q.flags[2];
  endproperty
  a_per_flag: assert property (p_per_flag)
    else $error("periodic event not latched");

  property p_off_per;
    !run |=> !tb.per_evt;
  endproperty
  a_off_per: assert property (p_off_per)
    else $error("periodic event while block idle");

  property p_alm_upd;
    $rose(st_q.flags[1]) |-> $past(i_update_done);
  endproperty
  a_alm_upd: assert property (p_alm_upd)
    else $error("alarm flag set outside an update");

  property p_dq;
    $rose(st_q.flags[1])
        |-> $past(st_q.dq == 6'h00 || st_q.dq == {2'h0, i_mon});
  endproperty
  a_dq: assert property (p_dq)
    else $error("alarm flag despite date qualifier mismatch");
endmodule : rcd_ctrl
`default_nettype wire

//--- rcd_pkg.sv
`default_nettype none
package rcd_pkg;
  localparam logic [7:0] OFS_ALM_SEC = 8'h01;
  localparam logic [7:0] OFS_ALM_MIN = 8'h03;
  localparam logic [7:0] OFS_ALM_HR = 8'h05;
  localparam logic [7:0] OFS_RATE = 8'h0A;
  localparam logic [7:0] OFS_CFG = 8'h0B;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_DATE_Q = 8'h0D;
  localparam logic [7:0] OFS_CTL = 8'h10;
  localparam logic [7:0] OFS_WDAY_Q = 8'h14;
  localparam logic [7:0] OFS_SPRING = 8'h18;
  localparam logic [7:0] OFS_FALL = 8'h1C;
  localparam int CFG_INHIBIT = 7;
  localparam int CFG_PIE = 6;
  localparam int CFG_UIE = 4;
  localparam int CFG_BIN = 2;
  localparam int CFG_H24 = 1;
  localparam int CFG_DST = 0;
  localparam logic [7:0] CFG_WMASK = 8'hF7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int CTL_ALM = 3;
  localparam int CTL_WAKE = 2;
  localparam int CTL_SOFT = 1;
  localparam int CTL_EN = 0;
  localparam logic [3:0] CTL_SOFT_MASK = 4'h2;
  localparam logic [7:0] DONT_CARE = 8'hFF;
  localparam logic [1:0] DC_TOP = 2'h3;
  localparam logic [1:0] DIV_HALT = 2'h3;
  localparam logic [5:0] LAST_MIN_SEC = 6'h3B;
  localparam logic [4:0] LAST_HOUR = 5'h17;
  localparam logic [2:0] LAST_WEEK = 3'h5;
  localparam int DIV_W = 15;
  localparam int UIP_LEAD_TICKS = 16;

  typedef struct packed {
    logic [4:0] hr;
    logic [2:0] wk;
    logic [2:0] wd;
    logic [7:0] mo;
  } rcd_sched_t;

  function automatic logic [3:0] rate_shift(input logic [3:0] code);
    unique case (code)
      4'h0: return 4'h0;
      4'h1: return 4'h7;
      4'h2: return 4'h8;
      default: return code - 4'h1;
    endcase
  endfunction : rate_shift

  function automatic logic [7:0] dec(input logic [7:0] v, input logic b);
    return b ? v : (8'(v[7:4]) * 8'h0A + 8'(v[3:0]));
  endfunction : dec

  function automatic logic [7:0] enc(input logic [7:0] v, input logic b);
    return b ? v : {4'(v / 8'h0A), 4'(v % 8'h0A)};
  endfunction : enc

  function automatic logic [4:0] hour_in(input logic [7:0] v,
      input logic b, input logic h24);
    logic [7:0] h;
    h = dec({1'b0, v[6:0]}, b);
    if (!h24) begin
      if (h == 8'h0C) h = 8'h00;
      if (v[7]) h = h + 8'h0C;
    end
    return 5'(h);
  endfunction : hour_in

  function automatic logic [7:0] hour_out(input logic [4:0] h,
      input logic b, input logic h24);
    logic [7:0] x;
    logic pm;
    x = {3'h0, h};
    pm = 1'b0;
    if (!h24) begin
      pm = x >= 8'h0C;
      if (pm) x = x - 8'h0C;
      if (x == 8'h00) x = 8'h0C;
    end
    return {pm, 7'(enc(x, b))};
  endfunction : hour_out

  function automatic logic [7:0] alm_in(input logic [7:0] v, input logic b,
      input logic h24, input logic is_hr);
    if (v[7:6] == DC_TOP) return DONT_CARE;
    return is_hr ? {3'h0, hour_in(v, b, h24)} : dec(v, b);
  endfunction : alm_in

  function automatic logic [7:0] alm_out(input logic [7:0] a, input logic b,
      input logic h24, input logic is_hr);
    if (a == DONT_CARE) return DONT_CARE;
    return is_hr ? hour_out(5'(a), b, h24) : enc(a, b);
  endfunction : alm_out

  function automatic logic wk_hit(input logic [2:0] code,
      input logic [4:0] md, input logic [4:0] mds);
    logic [2:0] wk;
    wk = 3'((md - 5'h01) / 5'h07) + 3'h1;
    if (code == LAST_WEEK) return ({1'b0, md} + 6'h07) > {1'b0, mds};
    return code == wk;
  endfunction : wk_hit

  function automatic logic sched_hit(input rcd_sched_t s,
      input logic [4:0] hr, input logic [2:0] wd, input logic [4:0] md,
      input logic [4:0] mds, input logic [3:0] mo);
    return s.hr == hr && s.wd == wd && wk_hit(s.wk, md, mds)
        && s.mo == {4'h0, mo};
  endfunction : sched_hit

  function automatic rcd_sched_t sched_wr(input rcd_sched_t s,
      input logic [31:0] w, input logic [3:0] be, input logic b,
      input logic h24);
    rcd_sched_t r;
    r = s;
    if (be[0]) r.mo = dec(w[7:0], b);
    if (be[1]) r.wd = w[10:8];
    if (be[2]) r.wk = w[18:16];
    if (be[3]) r.hr = hour_in(w[31:24], b, h24);
    return r;
  endfunction : sched_wr

  function automatic logic [31:0] sched_rd(input rcd_sched_t s,
      input logic b, input logic h24);
    return {hour_out(s.hr, b, h24), 5'h00, s.wk, 5'h00, s.wd, enc(s.mo, b)};
  endfunction : sched_rd
endpackage : rcd_pkg
`default_nettype wire

//--- rcd_tb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rcd_tb_if;
  logic tick;
  logic run;
  logic clr;
  logic [3:0] rate;
  logic per_evt;
  logic sec_evt;
  logic uip;
  modport ctl (output tick, run, clr, rate, input per_evt, sec_evt, uip);
  modport div (input tick, run, clr, rate, output per_evt, sec_evt, uip);
endinterface : rcd_tb_if
`default_nettype wire

//--- rcd_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module rcd_timebase #(
  parameter int DIV_BITS = rcd_pkg::DIV_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  rcd_tb_if.div tb
);
  import rcd_pkg::*;

  typedef struct packed {
    logic [DIV_BITS-1:0] cnt;
    logic per_q;
    logic sec_q;
    logic uip_q;
  } rcd_tb_st_t;

  localparam logic [DIV_BITS-1:0] UIP_AT = ~DIV_BITS'(UIP_LEAD_TICKS - 1);

  if (DIV_BITS < DIV_W) begin : g_bad
    $error("timebase divider too narrow for the rate table");
  end

  rcd_tb_st_t st_q;
  rcd_tb_st_t st_d;
  logic [DIV_BITS-1:0] nxt_cnt;
  logic [DIV_BITS-1:0] mask;

  assign nxt_cnt = st_q.cnt + 1'b1;
  assign mask = ~({DIV_BITS{1'b1}} << rate_shift(tb.rate));

  always_comb begin
    st_d = st_q;
    st_d.per_q = 1'b0;
    st_d.sec_q = 1'b0;
    if (tb.clr) begin
      st_d = '0;
    end else if (tb.run && tb.tick) begin
      st_d.cnt = nxt_cnt;
      // code 0 never fires
      st_d.per_q = tb.rate != 4'h0 && (nxt_cnt & mask) == '0;
      st_d.sec_q = nxt_cnt == '0;
    end
    // raised 16 slow ticks before the wrap, dropped by the wrap itself
    st_d.uip_q = tb.run && !tb.clr && st_d.cnt >= UIP_AT;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tb.per_evt = st_q.per_q;
  assign tb.sec_evt = st_q.sec_q;
  assign tb.uip = st_q.uip_q;
endmodule : rcd_timebase
`default_nettype wire

//--- test_rtc_control_alarm_dst.sv
`timescale 1ns/1ps
`default_nettype none
module test_rtc_control_alarm_dst;
  import rcd_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_clk_32k = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic [3:0] i_reg_be = 4'hF;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [5:0] i_sec = 6'h00;
  logic [5:0] i_min = 6'h00;
  logic [4:0] i_hour = 5'h00;
  logic [2:0] i_wday = 3'h1;
  logic [4:0] i_mday = 5'h01;
  logic [4:0] i_mon_days = 5'h1F;
  logic [3:0] i_mon = 4'h1;
  logic i_update_done = 1'b0;
  logic [31:0] o_reg_rdata;
  logic o_update_go, o_hour_extra, o_hour_hold, o_bin_mode, o_h24_mode;
  logic o_uip, o_running, o_irq, o_wake_alarm;
  logic [31:0] lfsr_q = 32'h18D4;
  logic [2:0] div32_q = 3'h0;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int wake_cnt = 0;

  rcd_ctrl #(.DIV_BITS(15)) dut_u (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_clk_32k(i_clk_32k),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_be(i_reg_be), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_sec(i_sec), .i_min(i_min),
    .i_hour(i_hour), .i_wday(i_wday), .i_mday(i_mday),
    .i_mon_days(i_mon_days), .i_mon(i_mon),
    .i_update_done(i_update_done), .o_update_go(o_update_go),
    .o_hour_extra(o_hour_extra), .o_hour_hold(o_hour_hold),
    .o_bin_mode(o_bin_mode), .o_h24_mode(o_h24_mode), .o_uip(o_uip),
    .o_running(o_running), .o_irq(o_irq), .o_wake_alarm(o_wake_alarm)
  );

  always #2 i_clk_sys = ~i_clk_sys;

  // slow clock: 4 system cycles per half period
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    div32_q <= div32_q + 3'h1;
    i_clk_32k <= div32_q[2];
    if (o_wake_alarm === 1'b1) wake_cnt <= wake_cnt + 1;
  end

  always @(posedge i_clk_sys) begin
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd

  function automatic int per_ticks(input logic [3:0] code);
    if (code == 4'h1) return 128;
    if (code == 4'h2) return 256;
    return 1 << (code - 4'h1);
  endfunction : per_ticks

  function automatic logic alarm_exp(input logic en, input logic [4:0] ah,
      input logic [4:0] hr, input logic [7:0] dq, input logic [3:0] mo,
      input logic [7:0] wq, input logic [2:0] wd);
    return en && ah == hr && (dq == 8'h00 || dq == {4'h0, mo})
        && (wq == 8'hFF || wq == {5'h00, wd});
  endfunction : alarm_exp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] b);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_be <= b;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rchk

  task automatic wait_irq(output int t);
    t = 0;
    for (int i = 0; i < 5000; i++) begin
      @(posedge i_clk_sys);
      #1;
      if (o_irq === 1'b1) begin
        t = cyc;
        return;
      end
    end
    err_total++;
    $display("MISMATCH t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
  endtask : wait_irq

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic [4:0] ah;
    logic [7:0] dq;
    logic [7:0] wq;
    logic al;
    int t1;
    int t2;
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    rchk(OFS_CFG, 32'h00);
    rchk(OFS_FLAGS, 32'h00);
    rchk(OFS_DATE_Q, 32'h00);
    rchk(OFS_CTL, 32'h00);
    rchk(OFS_WDAY_Q, 32'hFF);
    rchk(OFS_SPRING, 32'h1200_0000);
    rchk(OFS_FALL, 32'h1200_0000);
    rchk(8'h0E, 32'h00);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      wr(OFS_CFG, {24'h0, r[7:0]}, 4'hF);
      rchk(OFS_CFG, {24'h0, r[7:0] & 8'hF7});
      chk(o_bin_mode, r[2]);
      chk(o_h24_mode, r[1]);
    end
    wr(OFS_CFG, 32'h00, 4'hF);
    wr(OFS_CFG, 32'hFF, 4'h0);
    wr(OFS_FLAGS, 32'hF0, 4'hF);
    rchk(OFS_CFG, 32'h00);
    rchk(OFS_FLAGS, 32'h00);
    wr(OFS_WDAY_Q, 32'hC5, 4'hF);
    rchk(OFS_WDAY_Q, 32'hFF);
    wr(OFS_WDAY_Q, 32'h03, 4'hF);
    rchk(OFS_WDAY_Q, 32'h03);
    wr(OFS_DATE_Q, 32'hD2, 4'hF);
    rchk(OFS_DATE_Q, 32'h12);
    wr(OFS_CFG, 32'h06, 4'hF);
    wr(OFS_SPRING, 32'h1705_030C, 4'hF);
    rchk(OFS_SPRING, 32'h1705_030C);
    wr(OFS_CFG, 32'h00, 4'hF);
    rchk(OFS_SPRING, 32'h9105_0312);
    wr(OFS_SPRING, 32'h0000_0009, 4'h1);
    rchk(OFS_SPRING, 32'h9105_0309);
    wr(OFS_CFG, 32'h06, 4'hF);
    rchk(OFS_SPRING, 32'h1705_0309);
    // periodic events held off until the block is enabled
    wr(OFS_RATE, 32'h23, 4'hF);
    rchk(OFS_RATE, 32'h23);
    repeat (100) @(posedge i_clk_sys);
    rchk(OFS_FLAGS, 32'h00);
    chk(o_running, 1'b0);
    wr(OFS_CTL, 32'h01, 4'hF);
    #1 chk(o_running, 1'b1);
    repeat (100) @(posedge i_clk_sys);
    chk(o_irq, 1'b0);
    rchk(OFS_FLAGS, 32'h40);
    wr(OFS_CFG, 32'h46, 4'hF);
    wait_irq(t1);
    rchk(OFS_FLAGS, 32'hC0);
    for (int c = 1; c < 10; c++) begin
      wr(OFS_RATE, 32'h20 | c, 4'hF);
      rd(OFS_FLAGS, d);
      wait_irq(t1);
      rd(OFS_FLAGS, d);
      wait_irq(t2);
      chk(t2 - t1, per_ticks(4'(c)) * 8);
    end
    wr(OFS_RATE, 32'h20, 4'hF);
    repeat (4) @(posedge i_clk_sys);
    rd(OFS_FLAGS, d);
    repeat (300) @(posedge i_clk_sys);
    rchk(OFS_FLAGS, 32'h00);
    rchk(OFS_RATE, 32'h20);
    chk({28'h0, o_update_go, o_hour_extra, o_hour_hold, o_uip}, 32'h0);
    // alarm qualification, time held as plain binary 24-hour
    wr(OFS_CFG, 32'h26, 4'hF);
    wr(OFS_ALM_SEC, 32'hC0, 4'hF);
    wr(OFS_ALM_MIN, 32'hD5, 4'hF);
    rchk(OFS_ALM_SEC, 32'hFF);
    rchk(OFS_ALM_MIN, 32'hFF);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      @(posedge i_clk_sys);
      i_hour <= 5'(r[7:0] % 24);
      i_mon <= 4'(r[11:8] % 12 + 1);
      i_wday <= 3'(r[14:12] % 7 + 1);
      i_mday <= 5'(r[20:16] % 28 + 1);
      i_sec <= 6'(r[29:24] % 60);
      #1;
      ah = r[18] ? i_hour : 5'(r[23:19] % 24);
      dq = r[24] ? 8'h00
          : (r[25] ? {4'h0, i_mon} : {4'h0, 4'(i_mon % 12 + 1)});
      wq = r[26] ? 8'hFF
          : (r[27] ? {5'h0, i_wday} : {5'h0, 3'(i_wday % 7 + 1)});
      al = alarm_exp(r[16] | r[28], ah, i_hour, dq, i_mon, wq, i_wday);
      wr(OFS_ALM_HR, {27'h0, ah}, 4'hF);
      wr(OFS_DATE_Q, {24'h0, dq}, 4'hF);
      wr(OFS_WDAY_Q, {24'h0, wq}, 4'hF);
      wr(OFS_CTL, {28'h0, r[16] | r[28], r[17], 2'b01}, 4'hF);
      rd(OFS_FLAGS, d);
      t2 = wake_cnt;
      @(posedge i_clk_sys);
      i_update_done <= 1'b1;
      @(posedge i_clk_sys);
      i_update_done <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      chk(o_irq, al);
      rchk(OFS_FLAGS, {24'h0, al, 1'b0, al, 1'b1, 4'h0});
      chk(wake_cnt - t2, al & r[17]);
      rchk(OFS_FLAGS, 32'h00);
    end
    // soft reset keeps the control register but clears the rest
    wr(OFS_WDAY_Q, 32'h02, 4'hF);
    wr(OFS_CTL, 32'h0F, 4'hF);
    repeat (3) @(posedge i_clk_sys);
    rchk(OFS_CTL, 32'h0D);
    rchk(OFS_CFG, 32'h00);
    rchk(OFS_WDAY_Q, 32'hFF);
    rchk(OFS_ALM_SEC, 32'h00);
    report_and_stop();
  end
endmodule : test_rtc_control_alarm_dst
`default_nettype wire
